// ### hdl/acs_pkg.sv
// Constants shared by the conversion sequencer and its helpers.
// Assumes a single 40 MHz system clock.
package acs_pkg;
    // ==========================================
    // Clock and timing
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned SETTLE_NS = 10_000;
    localparam int unsigned CONV_NS = 10_000;
    // Least time rounds up, longest time rounds down
    localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
    localparam int unsigned TMR_W = 9;
    localparam logic [TMR_W-1:0] SETTLE_LOAD = TMR_W'(SETTLE_CYC - 1);
    localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYC - 1);
    // ==========================================
    // Register offsets
    localparam logic [3:0] OFS_SAMPLE_LO = 4'h0;
    localparam logic [3:0] OFS_SAMPLE_HI = 4'h1;
    localparam logic [3:0] OFS_CHAN_RANGE = 4'h2;
    localparam logic [3:0] OFS_CONV_STATUS = 4'h8;
    localparam logic [3:0] OFS_SETTLE_STATUS = 4'hA;
    localparam logic [3:0] OFS_SPAN_SELECT = 4'hB;
    // ==========================================
    // Field positions and reset values
    localparam int unsigned CHAN_LOW_LSB = 0;
    localparam int unsigned CHAN_HIGH_LSB = 4;
    localparam int unsigned BUSY_BIT = 7;
    localparam int unsigned ABORT_BIT = 6;
    localparam int unsigned SETTLE_BIT = 7;
    localparam int unsigned GAIN_LSB = 0;
    localparam int unsigned POLARITY_BIT = 2;
    localparam int unsigned FULL_SCALE_BIT = 3;
    localparam int unsigned SIGN_BIT = 15;
    localparam logic [3:0] SPAN_RESET = 4'h0;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam int unsigned BUF_DEPTH = 2;
    localparam int unsigned SAMPLE_W = 16;
endpackage

// ### hdl/acs_settle_timer.sv
// Settling timer: restartable down-counter that flags the settle window.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/10ps
module acs_settle_timer (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_n_in, // Synchronised reset
    input wire logic restart_in, // Channel or span write
    output logic settling_out // High while settling
);
    typedef struct packed {
        logic [acs_pkg::TMR_W-1:0] cnt;
        logic active;
    } acs_tmr_s;

    acs_tmr_s q, d;

    always_comb
    begin
        d = q;
        if (restart_in)
        begin
            // Re-arming keeps the flag up a full interval after the last write
            d.cnt = acs_pkg::SETTLE_LOAD;
            d.active = 1'b1;
        end
        else if (q.active)
        begin
            if (q.cnt == '0)
                d.active = 1'b0;
            else
                d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign settling_out = q.active;
endmodule

// ### hdl/acs_pair_buffer.sv
// Two-entry sample buffer between converter and result register.
// Assumes valid/ready handshakes on both sides, same clock.
`timescale 1ns/10ps
module acs_pair_buffer (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_n_in, // Synchronised reset
    input wire logic in_valid_in, // Word offered
    output logic in_ready_out, // Space available
    input wire logic [acs_pkg::SAMPLE_W-1:0] in_data_in, // Word in
    output logic out_valid_out, // Word held
    input wire logic out_ready_in, // Drain accepts
    output logic [acs_pkg::SAMPLE_W-1:0] out_data_out // Oldest word
);
    typedef struct packed {
        logic [acs_pkg::BUF_DEPTH-1:0][acs_pkg::SAMPLE_W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } acs_buf_s;

    acs_buf_s q, d;
    logic push;
    logic pop;

    always_comb
    begin
        d = q;
        push = in_valid_in && (q.count != 2'h2);
        pop = out_ready_in && (q.count != 2'h0);
        if (push)
        begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr = ~q.wr_ptr;
        end
        if (pop)
            d.rd_ptr = ~q.rd_ptr;
        d.count = q.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign in_ready_out = (q.count != 2'h2);
    assign out_valid_out = (q.count != 2'h0);
    assign out_data_out = q.mem[q.rd_ptr];
endmodule

// ### hdl/acs_top.sv
// Conversion sequencer: channel range, span select, settle and busy flags,
// software or hardware start, signed result read as two bytes.
// Assumes 8-bit I/O strobes on clk_sys_in and an external converter core.
// Function
// - Channel byte: low nibble is low channel, high nibble high channel.
// - Any channel write loads current channel with the new low channel.
// - After each completion the current channel steps by one in range, except after a conversion during which the channel was written.
// - Completion on the high channel wraps back to the low channel.
// - Channel or span writes start a ten microsecond settle timer.
// - Settle flag reads at offset 10 bit 7; host waits on it.
// - Write to offset 0 starts conversion when hardware trigger disabled.
// - With hardware trigger enabled, software starts ignored; pin edge starts.
// - A conversion may take up to ten microseconds.
// - Busy flag at offset 8 bit 7; host polls until zero.
// - Result low byte at offset 0, high byte at offset 1.
// - Result is signed two's complement, -32768 to +32767.
// - Unipolar keeps signed coding; zero input gives most negative code.
// - Span register at offset 11 accepts 0x08 for bipolar ten volts.
// - Span bits 1..0 select gain 1, 2, 4 or 8.
// - Span bit 3 picks 5V/10V, bit 2 bipolar/unipolar; unipolar 5V invalid.
// - Span register clears to zero at reset.
`timescale 1ns/10ps
module acs_top (
    input wire logic clk_sys_in, // 40 MHz system clock
    input wire logic nrst_in, // Async reset, active low
    input wire logic [3:0] bus_addr_in, // I/O offset
    input wire logic [7:0] bus_wdata_in, // Write data
    input wire logic bus_wr_in, // Write strobe, one cycle
    input wire logic bus_rd_in, // Read strobe, one cycle
    output logic [7:0] bus_rdata_out, // Read data, one cycle late
    input wire logic hw_trigger_enable_in, // Hardware start enable
    input wire logic hw_trigger_in, // Trigger pin, falling edge
    output logic conv_start_out, // Start pulse to converter
    output logic [3:0] conv_chan_out, // Channel being converted
    input wire logic sample_valid_in, // Converter word valid
    output logic sample_ready_out, // Buffer has room
    input wire logic [15:0] sample_in, // Offset-binary word
    output logic gain_select_high_out, // Gain bit 1
    output logic gain_select_low_out, // Gain bit 0
    output logic polarity_select_out, // 1 = unipolar
    output logic full_scale_out, // 1 = ten volt scale
    output logic span_invalid_out // Unipolar five volt
);
    // ==========================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ==========================================
    // State
    typedef struct packed {
        logic trg_s1;
        logic trg_s2;
        logic trg_s3;
        logic trg_lvl;
        logic [3:0] chan_low;
        logic [3:0] chan_high;
        logic [3:0] cur_chan;
        logic [3:0] conv_chan;
        logic [3:0] span;
        logic busy;
        logic conv_open;
        logic abort;
        logic chan_dirty;
        logic unread;
        logic start_pulse;
        logic [acs_pkg::TMR_W-1:0] conv_cnt;
        logic [15:0] result;
        logic [7:0] rdata;
    } acs_top_s;

    acs_top_s q, d;
    logic wr_start;
    logic wr_chan;
    logic wr_span;
    logic rd_hi;
    logic hw_edge;
    logic start;
    logic done;
    logic pop;
    logic buf_valid;
    logic buf_in_ready;
    logic [15:0] buf_data;
    logic settling;

    // ==========================================
    // Helpers
    acs_settle_timer u_settle (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .restart_in(wr_chan || wr_span),
        .settling_out(settling)
    );

    // Holding two words lets a late high-byte read stall without loss
    acs_pair_buffer u_buf (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .in_valid_in(sample_valid_in),
        .in_ready_out(buf_in_ready),
        .in_data_in(sample_in),
        .out_valid_out(buf_valid),
        .out_ready_in(~q.unread || rd_hi),
        .out_data_out(buf_data)
    );

    // ==========================================
    // Next state
    always_comb
    begin
        d = q;
        d.start_pulse = 1'b0;
        wr_start = bus_wr_in && (bus_addr_in == acs_pkg::OFS_SAMPLE_LO);
        wr_chan = bus_wr_in && (bus_addr_in == acs_pkg::OFS_CHAN_RANGE);
        wr_span = bus_wr_in && (bus_addr_in == acs_pkg::OFS_SPAN_SELECT);
        rd_hi = bus_rd_in && (bus_addr_in == acs_pkg::OFS_SAMPLE_HI);
        // Pin sampled by three stages; a level counts once the last two stages agree
        d.trg_s1 = hw_trigger_in;
        d.trg_s2 = q.trg_s1;
        d.trg_s3 = q.trg_s2;
        if (q.trg_s2 == q.trg_s3)
            d.trg_lvl = q.trg_s3;
        // Only falls count; the level resets low so release gives no false start
        hw_edge = q.trg_lvl && (q.trg_s2 == q.trg_s3) && !q.trg_s3;
        start = !q.busy && (hw_trigger_enable_in ? hw_edge : wr_start);
        done = sample_valid_in && buf_in_ready;
        pop = buf_valid && (~q.unread || rd_hi);

        // Channel stepping happens at completion, not at start
        if (done)
        begin
            if (q.chan_dirty)
                d.chan_dirty = 1'b0;
            else if (q.cur_chan == q.chan_high)
                d.cur_chan = q.chan_low;
            else
                d.cur_chan = q.cur_chan + 4'h1;
        end
        if (wr_chan)
        begin
            d.chan_low = bus_wdata_in[acs_pkg::CHAN_LOW_LSB +: 4];
            d.chan_high = bus_wdata_in[acs_pkg::CHAN_HIGH_LSB +: 4];
            d.cur_chan = bus_wdata_in[acs_pkg::CHAN_LOW_LSB +: 4];
            d.chan_dirty = q.busy && !done;
        end
        if (wr_span)
            d.span = bus_wdata_in[3:0];

        if (start)
        begin
            d.busy = 1'b1;
            d.conv_open = 1'b1;
            d.abort = 1'b0;
            d.start_pulse = 1'b1;
            d.conv_chan = q.cur_chan;
            d.conv_cnt = acs_pkg::CONV_LOAD;
        end
        else if (q.conv_open)
        begin
            // Converter gets its full window; silence beyond it is an abort
            if (done)
                d.conv_open = 1'b0;
            else if (q.conv_cnt == '0)
            begin
                d.conv_open = 1'b0;
                d.busy = 1'b0;
                d.abort = 1'b1;
            end
            else
                d.conv_cnt = q.conv_cnt - 1'b1;
        end

        if (pop)
        begin
            // Offset binary to two's complement: flip the top bit
            d.result = {~buf_data[acs_pkg::SIGN_BIT], buf_data[14:0]};
            d.unread = 1'b1;
            if (!start)
                d.busy = 1'b0;
        end
        else if (rd_hi)
            d.unread = 1'b0;

        case (bus_addr_in)
            acs_pkg::OFS_SAMPLE_LO: d.rdata = q.result[7:0];
            acs_pkg::OFS_SAMPLE_HI: d.rdata = q.result[15:8];
            acs_pkg::OFS_CONV_STATUS:
                d.rdata = {q.busy, q.abort, 2'b00, q.cur_chan};
            acs_pkg::OFS_SETTLE_STATUS: d.rdata = {settling, 7'h00};
            acs_pkg::OFS_SPAN_SELECT: d.rdata = {4'h0, q.span};
            default: d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.span <= acs_pkg::SPAN_RESET;
            q.cur_chan <= acs_pkg::CHAN_RESET;
        end
        else
            q <= d;
    end

    // ==========================================
    // Outputs
    assign bus_rdata_out = q.rdata;
    assign conv_start_out = q.start_pulse;
    assign conv_chan_out = q.conv_chan;
    assign sample_ready_out = buf_in_ready;
    assign gain_select_high_out = q.span[acs_pkg::GAIN_LSB + 1];
    assign gain_select_low_out = q.span[acs_pkg::GAIN_LSB];
    assign polarity_select_out = q.span[acs_pkg::POLARITY_BIT];
    assign full_scale_out = q.span[acs_pkg::FULL_SCALE_BIT];
    assign span_invalid_out = q.span[acs_pkg::POLARITY_BIT]
        && !q.span[acs_pkg::FULL_SCALE_BIT];

    // ==========================================
    // Checks
    localparam int CONV_BOUND = 401;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    AST_CHAN_HIGH: assert property (wr_chan |=> q.chan_high == $past(bus_wdata_in[7:4]))
        else $error("high channel not taken from upper nibble");
    AST_CHAN_LOAD: assert property (wr_chan |=> q.cur_chan == $past(bus_wdata_in[3:0]))
        else $error("current channel not loaded with low channel");
    AST_ADVANCE: assert property (done && !wr_chan && !q.chan_dirty
        && q.cur_chan != q.chan_high |=> q.cur_chan == $past(q.cur_chan) + 4'h1)
        else $error("channel did not advance");
    AST_WRAP: assert property (done && !wr_chan && !q.chan_dirty
        && q.cur_chan == q.chan_high |=> q.cur_chan == q.chan_low)
        else $error("channel did not wrap");
    AST_SETTLE: assert property ((wr_chan || wr_span) |=> settling [*8])
        else $error("settle flag not held after write");
    AST_SETTLE_READ: assert property (bus_addr_in == acs_pkg::OFS_SETTLE_STATUS
        |=> bus_rdata_out[7] == $past(settling))
        else $error("settle flag not shown at bit 7");
    AST_SW_START: assert property (wr_start && !hw_trigger_enable_in && !q.busy
        |=> conv_start_out && q.busy ##1 !conv_start_out)
        else $error("software start not honoured");
    AST_SW_IGNORE: assert property (wr_start && hw_trigger_enable_in && !hw_edge
        && !q.busy |=> !conv_start_out)
        else $error("software start not ignored");
    AST_CONV_WINDOW: assert property ($rose(q.conv_open) |-> ##[1:CONV_BOUND] !q.conv_open)
        else $error("conversion window not bounded");
    AST_SIGN: assert property (pop |=> q.result[15] == !$past(buf_data[15]))
        else $error("result not two's complement");
    AST_SPAN_WR: assert property (wr_span |=> q.span == $past(bus_wdata_in[3:0]))
        else $error("span register not written");

    // Read-back path: every byte shows one cycle after its address
    AST_BUSY_READ: assert property (bus_addr_in == acs_pkg::OFS_CONV_STATUS
        |=> bus_rdata_out[7] == $past(q.busy))
        else $error("busy flag not shown at bit 7");
    AST_LO_READ: assert property (bus_addr_in == acs_pkg::OFS_SAMPLE_LO
        |=> bus_rdata_out == $past(q.result[7:0]))
        else $error("low result byte not shown");
    AST_HI_READ: assert property (bus_addr_in == acs_pkg::OFS_SAMPLE_HI
        |=> bus_rdata_out == $past(q.result[15:8]))
        else $error("high result byte not shown");
    AST_SPAN_READ: assert property (bus_addr_in == acs_pkg::OFS_SPAN_SELECT
        |=> bus_rdata_out == {4'h0, $past(q.span)})
        else $error("span register not read back");

    // Starting, settling and completion
    AST_HW_START: assert property (hw_trigger_enable_in && hw_edge && !q.busy
        |=> conv_start_out)
        else $error("hardware start not honoured");
    AST_START_PULSE: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse longer than one cycle");
    AST_SETTLE_QUIET: assert property (!settling && !(wr_chan || wr_span) |=> !settling)
        else $error("settle flag rose without a write");
    AST_CHAN_HOLD: assert property (done && q.chan_dirty && !wr_chan
        |=> q.cur_chan == $past(q.cur_chan))
        else $error("channel stepped past a mid-conversion write");
    AST_TIMEOUT: assert property (q.conv_open && !start && !done && q.conv_cnt == '0
        |=> !q.busy && q.abort)
        else $error("conversion window not closed at its limit");
    AST_ZERO_CODE: assert property (pop && buf_data == 16'h0000
        |=> q.result == 16'h8000)
        else $error("zero input not coded most negative");

    // ==========================================
    // Coverage
    COV_SW_CONV: cover property (wr_start ##[1:CONV_BOUND] pop);
    COV_WRAP: cover property (done && q.cur_chan == q.chan_high && q.chan_low != q.chan_high);
    COV_HW_START: cover property (hw_trigger_enable_in && hw_edge && !q.busy);
    COV_BUF_FULL: cover property (!buf_in_ready);
    COV_ABORT: cover property (q.conv_open && !done && q.conv_cnt == '0);
endmodule

// ### testbench/acs_conv_model.sv
// Converter stand-in: answers each start pulse with one offset-binary word.
// Assumes one start at a time and a word held until the buffer takes it.
`timescale 1ns/10ps
module acs_conv_model (
    input wire logic clk_in, // System clock
    input wire logic start_in, // Start pulse
    input wire logic [3:0] chan_in, // Channel converted
    input wire logic ready_in, // Buffer has room
    input wire logic [11:0] lo12_in, // Low word part
    input wire logic [31:0] dly_in, // Cycles before the word
    output logic valid_out, // Word valid
    output logic [15:0] data_out // Offset-binary word
);
    int cnt = -1;
    logic taken;
    logic [15:0] word;
    initial
    begin
        valid_out = 1'b0;
        data_out = 16'h0000;
    end
    always @(posedge clk_in)
    begin
        taken = valid_out && ready_in;
        if (start_in)
        begin
            cnt = dly_in;
            word = {chan_in, lo12_in};
        end
        #1;
        if (taken)
            valid_out = 1'b0;
        if (cnt == 0)
        begin
            valid_out = 1'b1;
            data_out = word;
        end
        // Idle word keeps moving so a stale value never looks valid
        else if (!valid_out)
            data_out = ~data_out;
        if (cnt >= 0)
            cnt = cnt - 1;
    end
endmodule

// ### testbench/test_adc_conversion_sequencer.sv
// Testbench for the conversion sequencer: register tasks and scenarios.
// Assumes the converter stand-in answers every start pulse.
`timescale 1ns/10ps
module test_adc_conversion_sequencer;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic hw_en = 1'b0;
    logic hw_trig = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, d;
    logic start, svalid, sready, g1, g0, pol, fs, inv;
    logic [3:0] chan;
    logic [15:0] sword;
    logic [11:0] lo12 = 12'h5A3;
    int dly = 3;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int i;
    always #12.5 clk = ~clk;
    acs_top acs_top_i (.clk_sys_in(clk), .nrst_in(nrst), .bus_addr_in(addr),
        .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
        .hw_trigger_enable_in(hw_en), .hw_trigger_in(hw_trig), .conv_start_out(start),
        .conv_chan_out(chan), .sample_valid_in(svalid), .sample_ready_out(sready),
        .sample_in(sword), .gain_select_high_out(g1), .gain_select_low_out(g0),
        .polarity_select_out(pol), .full_scale_out(fs), .span_invalid_out(inv));
    acs_conv_model acs_conv_model_i (.clk_in(clk), .start_in(start), .chan_in(chan),
        .ready_in(sready), .lo12_in(lo12), .dly_in(dly), .valid_out(svalid),
        .data_out(sword));
    // ==========================================
    // Reporting
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            finish_test();
        end
    end
    // ==========================================
    // Register access
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        v = rdata;
    endtask
    // Polls bit 7 of a flag register; bound covers a full 400-cycle window
    task automatic wait_clear(input logic [3:0] a);
        for (int n = 0; n < 500; n++)
        begin
            rd_reg(a, d);
            if (d[7] === 1'b0)
                return;
        end
        chk("flag clear", 16'h0000, 16'h0001);
    endtask
    task automatic res(input logic [3:0] ch, input logic [11:0] l);
        logic [7:0] lo;
        rd_reg(4'h0, lo);
        rd_reg(4'h1, d);
        chk("result", {ch, l} ^ 16'h8000, {d, lo});
    endtask
    task automatic conv(input logic [3:0] ch);
        wr_reg(4'h0, 8'h00);
        wait_clear(4'h8);
        chk("chan", {12'h000, ch}, {12'h000, chan});
        res(ch, lo12);
    endtask
    // ==========================================
    // Scenarios
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'hB, d);
        chk("span reset", 16'h0000, {8'h00, d});
        rd_reg(4'h5, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        for (i = 0; i < 16; i++)
        begin
            wr_reg(4'hB, i[7:0]);
            rd_reg(4'hB, d);
            chk("span", {8'h00, i[7:0]}, {8'h00, d});
            chk("span pins", {11'h000, i[3:2] == 2'b01, i[3:0]},
                {11'h000, inv, fs, pol, g1, g0});
        end
        wr_reg(4'hB, 8'h08);
        rd_reg(4'hA, d);
        chk("settling", 16'h0001, {15'h0000, d[7]});
        repeat (300) @(posedge clk);
        wr_reg(4'h2, 8'h20);
        repeat (300) @(posedge clk);
        rd_reg(4'hA, d);
        chk("settle restart", 16'h0001, {15'h0000, d[7]});
        wait_clear(4'hA);
        lo12 = 12'h000;
        conv(4'h0);
        lo12 = 12'h5A3;
        dly = 390;
        conv(4'h1);
        dly = 0;
        conv(4'h2);
        conv(4'h0);
        // Channel rewrite lands while a conversion runs
        dly = 100;
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h2, 8'h53);
        wait_clear(4'h8);
        res(4'h1, lo12);
        wait_clear(4'hA);
        dly = 2;
        conv(4'h3);
        conv(4'h4);
        conv(4'h5);
        conv(4'h3);
        wr_reg(4'h2, 8'h77);
        wait_clear(4'hA);
        conv(4'h7);
        conv(4'h7);
        hw_en = 1'b1;
        lo12 = 12'h0F0;
        wr_reg(4'h0, 8'h00);
        repeat (10) @(posedge clk);
        rd_reg(4'h8, d);
        chk("soft start ignored", 16'h0000, {15'h0000, d[7]});
        res(4'h7, 12'h5A3);
        lo12 = 12'h3C6;
        hw_trig = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        hw_trig = 1'b1;
        wait_clear(4'h8);
        res(4'h7, 12'h3C6);
        lo12 = 12'h5A3;
        hw_en = 1'b0;
        // Second word waits in the buffer behind an unread result
        wr_reg(4'h0, 8'h00);
        wait_clear(4'h8);
        lo12 = 12'h111;
        wr_reg(4'h0, 8'h00);
        repeat (20) @(posedge clk);
        rd_reg(4'h8, d);
        chk("busy while unread", 16'h0001, {15'h0000, d[7]});
        res(4'h7, 12'h5A3);
        wait_clear(4'h8);
        res(4'h7, 12'h111);
        // Converter silent past the window: busy drops, abort shows
        dly = 450;
        wr_reg(4'h0, 8'h00);
        wait_clear(4'h8);
        rd_reg(4'h8, d);
        chk("abort status", 16'h0047, {8'h00, d});
        finish_test();
    end
endmodule
